// ---- pme_host_model.sv ----
// host side of the interrupt pin: pull-up and wired line seen by the controller
`timescale 1ns/1ns
module pme_host_model (
    input wire logic int_o,
    input wire logic int_oe_n,
    output logic int_line
);
    // ----------------------------------------
    // open-drain line with host pull-up
    // ----------------------------------------
    // released line must read high, never the last driven level
    assign int_line = int_oe_n ? 1'b1 : int_o;
endmodule

// ---- pme_monitor.sv ----
// pir motion event monitor with apb register access
// ----------------------------------------
// Overview of operation
// R1: interrupt pin driven low for an event, released otherwise
// R2: host pulls the interrupt line high when nobody drives it
// R3: bus address 0x12 with strap closed, 0x13 with strap open
// R4: raw status bit mirrors the sensor output, undebounced
// R5: arrival flag sets after raw goes active and holds for debounce time
// R6: departure flag sets after raw goes inactive and holds for debounce time
// R7: sixteen-bit debounce time in ms, read/write, 750 after reset
// R8: interrupt enabled means every arrival and departure asserts the pin
// R9: interrupt disabled means no pin assertion, flags still update
// R10: event-pending bit set by any debounced event until cleared
// R11: clear command zeroes arrival, departure and pending together
// R12: interrupt reset command restores defaults, interrupts off
// R13: ten-entry arrival timestamp queue with full and empty flags
// R14: ten-entry departure timestamp queue with full and empty flags
// R15: elapsed ms since latest arrival and since latest departure
// R16: elapsed ms of the oldest entry in each queue, no removal
// R17: pop returns the oldest queue entry then discards it
// R18: sixteen-bit firmware version, major high byte, minor low byte
// R19: readable eight-bit identification value
// R20: host-written bus address is used from then on
// R21: clearing event bits releases the interrupt pin high
// R22: timestamps from free-running ms counter, elapsed is now minus entry
// ----------------------------------------
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module pme_monitor
    import pme_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pir_raw,
    input wire logic addr_strap_open,
    output logic int_o,
    output logic int_oe_n,
    output logic [6:0] bus_addr
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] pir_sync;
        logic [2:0] strap_sync;
        logic raw;
        logic strap;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [TS_W-1:0] now;
        logic stable;
        logic [15:0] dcnt;
        logic arrival_flag;
        logic departure_flag;
        logic event_pending;
        logic [TS_W-1:0] last_arr;
        logic [TS_W-1:0] last_dep;
        logic seen_arr;
        logic seen_dep;
        logic int_en;
        logic [15:0] debounce;
        logic [6:0] addr;
        logic addr_sw;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic int_o;
        logic int_oe_n;
    } pme_state_t;

    pme_state_t st_q;
    pme_state_t st_d;

    logic arr_evt;
    logic dep_evt;
    logic access;
    logic take;
    logic wr_take;
    logic rd_take;
    logic hit;
    logic pop_arr;
    logic pop_dep;
    logic [31:0] rdata;
    logic [TS_W-1:0] arr_head;
    logic [TS_W-1:0] dep_head;
    logic arr_full;
    logic arr_empty;
    logic dep_full;
    logic dep_empty;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    // ----------------------------------------
    // timestamp queues
    // ----------------------------------------
    pme_ts_queue u_arr_queue (
        .clock(clock),
        .nrst(nrst),
        .push(arr_evt),
        .push_data(st_q.now),
        .pop(pop_arr),
        .head(arr_head),
        .full(arr_full),
        .empty(arr_empty)
    );

    pme_ts_queue u_dep_queue (
        .clock(clock),
        .nrst(nrst),
        .push(dep_evt),
        .push_data(st_q.now),
        .pop(pop_dep),
        .head(dep_head),
        .full(dep_full),
        .empty(dep_empty)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        hit = 1'h1;
        rdata = 32'h0;
        case (paddr)
            REG_ID: begin
                rdata = {24'h0, DEVICE_ID};  // R19
            end
            REG_VERSION: begin
                rdata = {16'h0, FW_VERSION};  // R18
            end
            REG_STATUS: begin
                rdata[ST_RAW] = st_q.raw;  // R4
                rdata[ST_ARRIVAL] = st_q.arrival_flag;
                rdata[ST_DEPARTURE] = st_q.departure_flag;
                rdata[ST_PENDING] = st_q.event_pending;  // R10
                rdata[ST_ARR_FULL] = arr_full;  // R13
                rdata[ST_ARR_EMPTY] = arr_empty;  // R13
                rdata[ST_DEP_FULL] = dep_full;  // R14
                rdata[ST_DEP_EMPTY] = dep_empty;  // R14
            end
            REG_CTRL: begin
                rdata[CTRL_INT_EN] = st_q.int_en;
            end
            REG_CMD: begin
                rdata = 32'h0;
            end
            REG_DEBOUNCE: begin
                rdata = {16'h0, st_q.debounce};  // R7
            end
            REG_BUSADDR: begin
                rdata = {25'h0, st_q.addr};
            end
            REG_LAST_ARR: begin
                rdata = st_q.seen_arr ? st_q.now - st_q.last_arr : 32'h0;  // R15
            end
            REG_LAST_DEP: begin
                rdata = st_q.seen_dep ? st_q.now - st_q.last_dep : 32'h0;  // R15
            end
            REG_FIRST_ARR: begin
                rdata = arr_empty ? 32'h0 : st_q.now - arr_head;  // R16 R22
            end
            REG_FIRST_DEP: begin
                rdata = dep_empty ? 32'h0 : st_q.now - dep_head;  // R16 R22
            end
            REG_POP_ARR: begin
                rdata = arr_head;  // R17
            end
            REG_POP_DEP: begin
                rdata = dep_head;  // R17
            end
            default: begin
                hit = 1'h0;
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        arr_evt = 1'h0;
        dep_evt = 1'h0;
        access = psel && penable;
        take = access && st_q.pready;
        wr_take = take && pwrite && !st_q.pslverr;
        rd_take = take && !pwrite;
        pop_arr = rd_take && (paddr == REG_POP_ARR);  // R17
        pop_dep = rd_take && (paddr == REG_POP_DEP);  // R17

        // three-stage synchronisers, a change counts when stages two and three agree
        st_d.pir_sync = {st_q.pir_sync[1:0], pir_raw};
        st_d.strap_sync = {st_q.strap_sync[1:0], addr_strap_open};
        if (st_q.pir_sync[1] == st_q.pir_sync[2]) begin
            st_d.raw = st_q.pir_sync[2];  // R4
        end
        if (st_q.strap_sync[1] == st_q.strap_sync[2]) begin
            st_d.strap = st_q.strap_sync[2];
        end

        // millisecond tick and free-running timestamp
        st_d.tick = 1'h0;
        if (st_q.div == DIV_LAST) begin
            st_d.div = '0;
            st_d.tick = 1'h1;
        end else begin
            st_d.div = st_q.div + 1'h1;
        end
        if (st_q.tick) begin
            st_d.now = st_q.now + 32'h1;  // R22
        end

        // debounce: any return to the held level restarts the count; firing only on a tick
        // after the full count keeps the hold from falling short of the setting
        if (st_q.raw == st_q.stable) begin
            st_d.dcnt = 16'h0;
        end else if (st_q.tick && st_q.dcnt >= st_q.debounce) begin
            st_d.stable = st_q.raw;
            st_d.dcnt = 16'h0;
            arr_evt = st_q.raw;  // R5
            dep_evt = !st_q.raw;  // R6
        end else if (st_q.tick) begin
            st_d.dcnt = st_q.dcnt + 16'h1;
        end

        // apb: one wait cycle so read data comes from a flop
        st_d.pready = access && !st_q.pready;
        if (access && !st_q.pready) begin
            st_d.prdata = rdata;
            st_d.pslverr = !hit;
        end else begin
            st_d.pslverr = 1'h0;
        end

        if (wr_take && paddr == REG_CTRL) begin
            st_d.int_en = pwdata[CTRL_INT_EN];
        end
        if (wr_take && paddr == REG_DEBOUNCE) begin
            st_d.debounce = pwdata[15:0];  // R7
        end
        if (wr_take && paddr == REG_CMD && pwdata[CMD_INT_RESET]) begin
            st_d.int_en = INT_EN_RST;  // R12
        end
        if (wr_take && paddr == REG_CMD && pwdata[CMD_CLEAR]) begin
            st_d.arrival_flag = 1'h0;  // R11
            st_d.departure_flag = 1'h0;  // R11
            st_d.event_pending = 1'h0;  // R11
        end

        // a new event wins over a clear in the same cycle
        if (arr_evt) begin
            st_d.arrival_flag = 1'h1;  // R5
            st_d.event_pending = 1'h1;  // R10
            st_d.last_arr = st_q.now;  // R15
            st_d.seen_arr = 1'h1;
        end
        if (dep_evt) begin
            st_d.departure_flag = 1'h1;  // R6
            st_d.event_pending = 1'h1;  // R10
            st_d.last_dep = st_q.now;  // R15
            st_d.seen_dep = 1'h1;
        end

        // bus address: strap until software takes it over
        if (wr_take && paddr == REG_BUSADDR) begin
            st_d.addr = pwdata[6:0];  // R20
            st_d.addr_sw = 1'h1;  // R20
        end else if (!st_q.addr_sw) begin
            st_d.addr = st_q.strap ? BUS_ADDR_OPEN : BUS_ADDR_CLOSED;  // R3
        end

        // open drain: output level fixed low, only the enable moves
        st_d.int_o = 1'h0;  // R1
        st_d.int_oe_n = !(st_d.int_en && st_d.event_pending);  // R1 R8 R9 R21
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.debounce <= DEBOUNCE_RST;  // R7
            st_q.int_en <= INT_EN_RST;
            st_q.addr <= BUS_ADDR_CLOSED;
            st_q.int_oe_n <= 1'h1;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign int_o = st_q.int_o;
    assign int_oe_n = st_q.int_oe_n;
    assign bus_addr = st_q.addr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_int_low_when_driven: assert property (!int_oe_n |-> (int_o == 1'h0) && st_q.event_pending) // R1
        else $error("interrupt driven without a pending event or not low");
    chk_int_follows_pending: assert property ((st_q.int_en && st_q.event_pending) |-> !int_oe_n) // R8
        else $error("enabled pending event did not drive interrupt");
    chk_int_masked_off: assert property (!st_q.int_en |-> int_oe_n) // R9
        else $error("interrupt driven while disabled");
    chk_arrival_after_hold: assert property (arr_evt |-> st_q.raw && !st_q.stable && st_q.tick // R5
        && st_q.dcnt >= st_q.debounce ##1 st_q.arrival_flag && st_q.event_pending)
        else $error("arrival flagged before debounce time");
    chk_departure_after_hold: assert property (dep_evt |-> !st_q.raw && st_q.stable && st_q.tick // R6
        && st_q.dcnt >= st_q.debounce ##1 st_q.departure_flag && st_q.event_pending)
        else $error("departure flagged before debounce time");
    chk_clear_events_all: assert property ((wr_take && paddr == REG_CMD && pwdata[CMD_CLEAR] // R11 R21
        && !arr_evt && !dep_evt) |=> !st_q.arrival_flag && !st_q.departure_flag && !st_q.event_pending
        && int_oe_n)
        else $error("clear did not zero event bits and release interrupt");
    chk_int_cfg_reset: assert property ((wr_take && paddr == REG_CMD && pwdata[CMD_INT_RESET]) // R12
        |=> !st_q.int_en && int_oe_n)
        else $error("interrupt reset left interrupts on");
    chk_addr_from_strap: assert property ((!st_q.addr_sw && !wr_take) |=> // R3
        bus_addr == ($past(st_q.strap) ? BUS_ADDR_OPEN : BUS_ADDR_CLOSED))
        else $error("bus address does not follow the strap");
    chk_addr_sw_write: assert property ((wr_take && paddr == REG_BUSADDR) |=> // R20
        bus_addr == $past(pwdata[6:0]) && st_q.addr_sw)
        else $error("written bus address not taken");
    chk_pending_has_cause: assert property ($rose(st_q.event_pending) |-> // R10
        st_q.arrival_flag || st_q.departure_flag)
        else $error("pending set without an event flag");
    chk_apb_one_wait: assert property ((access && !pready) |=> pready ##1 !pready)
        else $error("apb answer not in second access cycle");

    cov_arrival_event: cover property (arr_evt);
    cov_departure_event: cover property (dep_evt);
    cov_interrupt_driven: cover property ($fell(int_oe_n));
    cov_pop_arrival: cover property (pop_arr && !arr_empty);

endmodule

// ---- pme_pkg.sv ----
// constants and register map of the pir motion event monitor
package pme_pkg;

    // ----------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------
    localparam int PADDR_W = 8;
    localparam logic [7:0] REG_ID = 8'h00;
    localparam logic [7:0] REG_VERSION = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_CMD = 8'h10;
    localparam logic [7:0] REG_DEBOUNCE = 8'h14;
    localparam logic [7:0] REG_BUSADDR = 8'h18;
    localparam logic [7:0] REG_LAST_ARR = 8'h1C;
    localparam logic [7:0] REG_LAST_DEP = 8'h20;
    localparam logic [7:0] REG_FIRST_ARR = 8'h24;
    localparam logic [7:0] REG_FIRST_DEP = 8'h28;
    localparam logic [7:0] REG_POP_ARR = 8'h2C;
    localparam logic [7:0] REG_POP_DEP = 8'h30;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ST_RAW = 0;
    localparam int ST_ARRIVAL = 1;
    localparam int ST_DEPARTURE = 2;
    localparam int ST_PENDING = 3;
    localparam int ST_ARR_FULL = 4;
    localparam int ST_ARR_EMPTY = 5;
    localparam int ST_DEP_FULL = 6;
    localparam int ST_DEP_EMPTY = 7;
    localparam int CTRL_INT_EN = 0;
    localparam int CMD_CLEAR = 0;
    localparam int CMD_INT_RESET = 1;

    // ----------------------------------------
    // values after reset and identity
    // ----------------------------------------
    localparam logic [6:0] BUS_ADDR_CLOSED = 7'h12;
    localparam logic [6:0] BUS_ADDR_OPEN = 7'h13;
    // 750 ms
    localparam logic [15:0] DEBOUNCE_RST = 16'h02EE;
    localparam logic INT_EN_RST = 1'h0;
    // arbitrary values
    localparam logic [7:0] DEVICE_ID = 8'h5A;
    localparam logic [15:0] FW_VERSION = 16'h0100;

    // ----------------------------------------
    // queues and timing
    // ----------------------------------------
    localparam int TS_W = 32;
    localparam int QIDX_W = 4;
    localparam logic [3:0] QUEUE_DEPTH = 4'hA;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int DIV_W = 17;

endpackage

// ---- pme_ts_queue.sv ----
// ten-entry timestamp queue, first in first out
`timescale 1ns/1ns
module pme_ts_queue
    import pme_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic push,
    input wire logic [TS_W-1:0] push_data,
    input wire logic pop,
    output logic [TS_W-1:0] head,
    output logic full,
    output logic empty
);

    typedef struct packed {
        logic [9:0][TS_W-1:0] mem;
        logic [QIDX_W-1:0] rd;
        logic [QIDX_W-1:0] wr;
        logic [QIDX_W-1:0] cnt;
        logic [TS_W-1:0] head;
        logic full;
        logic empty;
    } pme_q_state_t;

    pme_q_state_t st_q;
    pme_q_state_t st_d;
    logic do_push;
    logic do_pop;

    always_comb begin
        st_d = st_q;
        // a push into a full queue is dropped so the oldest entries survive
        do_push = push && !st_q.full;
        do_pop = pop && !st_q.empty;
        if (do_push) begin
            st_d.mem[st_q.wr] = push_data;
            st_d.wr = (st_q.wr == QUEUE_DEPTH - 4'h1) ? 4'h0 : st_q.wr + 4'h1;
        end
        if (do_pop) begin
            st_d.rd = (st_q.rd == QUEUE_DEPTH - 4'h1) ? 4'h0 : st_q.rd + 4'h1;  // R17
        end
        if (do_push && !do_pop) begin
            st_d.cnt = st_q.cnt + 4'h1;
        end else if (do_pop && !do_push) begin
            st_d.cnt = st_q.cnt - 4'h1;
        end
        st_d.full = (st_d.cnt == QUEUE_DEPTH);
        st_d.empty = (st_d.cnt == 4'h0);
        st_d.head = st_d.empty ? 32'h0 : st_d.mem[st_d.rd];
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.empty <= 1'h1;
        end else begin
            st_q <= st_d;
        end
    end

    assign head = st_q.head;
    assign full = st_q.full;
    assign empty = st_q.empty;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_queue_flags_consistent: assert property (@(posedge clock) disable iff (!nrst) // R13
        (st_q.full == (st_q.cnt == QUEUE_DEPTH)) && (st_q.empty == (st_q.cnt == 4'h0)) && !(full && empty))
        else $error("queue full or empty flag disagrees with count");
    chk_pop_fifo_order: assert property (@(posedge clock) disable iff (!nrst) // R17
        (pop && !empty && !push) |=> (st_q.cnt == $past(st_q.cnt) - 4'h1) && (st_q.rd != $past(st_q.rd)))
        else $error("pop did not remove the oldest entry");
    cov_queue_fills: cover property (@(posedge clock) disable iff (!nrst) $rose(full));

endmodule

// ---- testbench.sv ----
// self-checking testbench of the pir motion event monitor
`timescale 1ns/1ns
module testbench;
    import pme_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int MSC = 10;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pir_raw = 1'b0;
    logic addr_strap_open = 1'b0;
    logic int_o;
    logic int_oe_n;
    logic int_line;
    logic [6:0] bus_addr;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] prev;
    logic [31:0] first_v;
    logic [6:0] new_addr;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 44380;

    pme_monitor #(.MS_CYCLES(MSC)) uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pir_raw(pir_raw), .addr_strap_open(addr_strap_open), .int_o(int_o),
        .int_oe_n(int_oe_n), .bus_addr(bus_addr));
    pme_host_model host (.int_o(int_o), .int_oe_n(int_oe_n), .int_line(int_line));

    always #4 clock = ~clock;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
            n++;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // the slave answers in the second access cycle
        check(32'(n), 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    function automatic logic [31:0] st_exp(input logic raw, arr, dep, pend, af, ae, df, de);
        return {24'h0, de, df, ae, af, pend, dep, arr, raw};
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        wait_cyc(6);
        nrst <= 1'b1;
        wait_cyc(6);
        check({25'h0, bus_addr}, 32'h12);
        rd_chk(REG_ID, {24'h0, DEVICE_ID});
        rd_chk(REG_VERSION, {16'h0, FW_VERSION});
        rd_chk(REG_DEBOUNCE, 32'h2EE);
        rd_chk(REG_STATUS, st_exp(0, 0, 0, 0, 0, 1, 0, 1));
        rd_chk(REG_CTRL, 32'h0);
        xfer(1'b1, REG_DEBOUNCE, 32'h3);
        rd_chk(REG_DEBOUNCE, 32'h3);
        xfer(1'b1, REG_CTRL, 32'h1);
        // glitch shorter than the hold restarts the count
        pir_raw <= 1'b1;
        wait_cyc(5 + ($unsigned($random(seed)) % 10));
        pir_raw <= 1'b0;
        wait_cyc(6 * MSC);
        rd_chk(REG_STATUS, st_exp(0, 0, 0, 0, 0, 1, 0, 1));
        pir_raw <= 1'b1;
        wait_cyc(3 * MSC);
        rd_chk(REG_STATUS, st_exp(1, 0, 0, 0, 0, 1, 0, 1));
        wait_cyc(4 * MSC);
        rd_chk(REG_STATUS, st_exp(1, 1, 0, 1, 0, 0, 0, 1));
        check({31'h0, int_line}, 32'h0);
        xfer(1'b1, REG_CMD, 32'h1);
        rd_chk(REG_STATUS, st_exp(1, 0, 0, 0, 0, 0, 0, 1));
        check({31'h0, int_line}, 32'h1);
        pir_raw <= 1'b0;
        wait_cyc(3 * MSC);
        rd_chk(REG_STATUS, st_exp(0, 0, 0, 0, 0, 0, 0, 1));
        wait_cyc(4 * MSC);
        rd_chk(REG_STATUS, st_exp(0, 0, 1, 1, 0, 0, 0, 0));
        check({31'h0, int_line}, 32'h0);
        xfer(1'b1, REG_CMD, 32'h3);
        rd_chk(REG_CTRL, 32'h0);
        check({31'h0, int_line}, 32'h1);
        pir_raw <= 1'b1;
        wait_cyc(6 * MSC);
        rd_chk(REG_STATUS, st_exp(1, 1, 0, 1, 0, 0, 0, 0));
        check({31'h0, int_line}, 32'h1);
        pir_raw <= 1'b0;
        wait_cyc(6 * MSC);
        check({31'h0, int_line}, 32'h1);
        // drain the two entries of each queue, then ten arrivals and ten departures at debounce zero
        repeat (2) xfer(1'b0, REG_POP_ARR, 32'h0);
        repeat (2) xfer(1'b0, REG_POP_DEP, 32'h0);
        xfer(1'b1, REG_CMD, 32'h1);
        rd_chk(REG_STATUS, st_exp(0, 0, 0, 0, 0, 1, 0, 1));
        xfer(1'b1, REG_DEBOUNCE, 32'h0);
        repeat (10) begin
            pir_raw <= 1'b1;
            wait_cyc(15);
            pir_raw <= 1'b0;
            wait_cyc(15);
        end
        wait_cyc(5);
        rd_chk(REG_STATUS, st_exp(0, 1, 1, 1, 1, 0, 1, 0));
        xfer(1'b0, REG_FIRST_ARR, 32'h0);
        first_v = rdata;
        xfer(1'b0, REG_LAST_ARR, 32'h0);
        // both reads may straddle one ms tick
        check({31'h0, (first_v - rdata) inside {32'd26, 32'd27}}, 32'h1);
        xfer(1'b0, REG_FIRST_ARR, 32'h0);
        check({31'h0, (rdata - first_v) <= 32'd1}, 32'h1);
        for (int q = 0; q < 2; q++) begin
            for (int i = 0; i < 10; i++) begin
                xfer(1'b0, (q == 0) ? REG_POP_ARR : REG_POP_DEP, 32'h0);
                if (i > 0) begin
                    check(rdata - prev, 32'h3);
                end
                prev = rdata;
            end
            rd_chk((q == 0) ? REG_POP_ARR : REG_POP_DEP, 32'h0);
        end
        rd_chk(REG_STATUS, st_exp(0, 1, 1, 1, 0, 1, 0, 1));
        addr_strap_open <= 1'b1;
        wait_cyc(10);
        check({25'h0, bus_addr}, 32'h13);
        new_addr = 7'h20 + 7'($unsigned($random(seed)) % 64);
        xfer(1'b1, REG_BUSADDR, {25'h0, new_addr});
        rd_chk(REG_BUSADDR, {25'h0, new_addr});
        addr_strap_open <= 1'b0;
        wait_cyc(10);
        check({25'h0, bus_addr}, {25'h0, new_addr});
        xfer(1'b0, 8'h40 + 8'(4 * ($unsigned($random(seed)) % 32)), 32'h0);
        check({rdata[31:1], rerr}, 32'h1);
        conclude();
    end
endmodule
